// File: src/cmc_clock_ctrl.sv
// Operation
// - High-speed source or slow internal RC may drive the system clock.
// - Normal mode instruction clock is high clock divided by build factor 4..16.
// - Slow mode instruction clock is slow RC clock divided by four.
// - Stop bit one halts the high oscillator only while the slow RC clock is selected; slow RC keeps running.
// - Clock select bit two: zero high clock, one slow RC clock.
// - Mode field bits 4:3: normal, sleep, green, reserved.
// - Sleep stops both high oscillator and slow RC.
// - Build option picks fast RC, external RC, 32K, 12M or 4M crystal.
// - Internal fast RC option turns both oscillator pins into general I/O.
// - External clock or RC takes input pin; output pin becomes general I/O.
// - Start-up wait is short for RC types, longer for crystals.
// - Slow RC stops only in sleep and its wake wait, or green with 32K and no watchdog.
// - No software bit stops the slow RC on its own.
// - Slow RC clocks the watchdog and the slow mode system clock.
// - Sleep wake waits 2048 high oscillator clocks, then enters normal mode.
// - Green wake returns to the previous mode with no settling wait.
// - Port level change wakes both low-power modes; timer overflow wakes green only.
`timescale 1ns/1ns
`default_nettype none
module cmc_clock_ctrl
  import cmc_pkg::*;
#(
  parameter cmc_high_clock_config_t   HIGH_CLK_OPT   = HIGH_CLOCK_CONFIG_INT_FAST_RC,
  parameter int          CPU_DIV        = 4,
  parameter bit          WDT_EN         = 1'b1,
  parameter int          WAKE_W         = 8,
  parameter logic [11:0] RC_START_TICKS = STARTUP_RC_TICKS,
  parameter logic [11:0] XT_START_TICKS = STARTUP_XTAL_TICKS
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Avalon-MM slave
  input  wire logic [11:0]       avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Oscillator inputs, asynchronous
  input  wire logic              fast_osc_i,
  input  wire logic              slow_osc_i,
  // Wake sources
  input  wire logic [WAKE_W-1:0] wake_port_i,
  input  wire logic              timer_ovf_i,
  // Oscillator enables and pin roles
  output logic                   high_osc_en_o,
  output logic                   slow_rc_en_o,
  output logic                   osc_input_gpio_o,
  output logic                   osc_output_gpio_o,
  // Clock results
  output logic                   cpu_clk_o,
  output logic                   cpu_tick_o,
  output logic                   cpu_run_o,
  output logic                   wdt_tick_o,
  output logic                   slow_sel_o
);

  // Build-time checks, refused at elaboration
  if (CPU_DIV < CPU_DIV_MIN || CPU_DIV > CPU_DIV_MAX) begin : g_bad_div
    $error("CPU_DIV out of range");
  end
  if (WAKE_W < 1) begin : g_bad_wake_w
    $error("WAKE_W must be positive");
  end
  // A zero start-up count would wrap the compare and wait a full counter span
  if (RC_START_TICKS == 12'h000 || XT_START_TICKS == 12'h000) begin : g_bad_start
    $error("start-up tick counts must be nonzero");
  end

  localparam logic [4:0]  FAST_DIV    = 5'(CPU_DIV);
  localparam bit          RC_TYPE     = (HIGH_CLK_OPT == HIGH_CLOCK_CONFIG_INT_FAST_RC) ||
                                        (HIGH_CLK_OPT == HIGH_CLOCK_CONFIG_EXT_RC);
  localparam logic [11:0] START_TICKS = RC_TYPE ? RC_START_TICKS : XT_START_TICKS;

  logic              high_osc_stop_q;
  logic              clock_source_select_q;
  logic [1:0]        operating_mode_q;
  logic              ack_q;
  logic              hit;
  logic              wr_take;
  logic              wake_clear;
  logic              sleep_exit;
  cmc_state_t        state_q;
  logic [11:0]       tick_cnt_q;
  logic              sel_slow_q;
  logic [2:0]        fast_sy_q;
  logic [2:0]        slow_sy_q;
  logic [WAKE_W-1:0] port_sy1_q;
  logic [WAKE_W-1:0] port_sy2_q;
  logic [WAKE_W-1:0] port_old_q;
  logic              port_change;
  logic              fast_tick;
  logic              slow_tick;
  logic              src_tick;
  logic [4:0]        src_div;
  logic              boundary;
  logic              run_div;

  // Map a write value onto the mode field; the reserved code is stored as normal
  function automatic logic [1:0] mode_of(input logic [7:0] wdata);
    logic [1:0] m;
    m = wdata[MODE_MSB:MODE_LSB];
    mode_of = (m == MODE_RSVD) ? MODE_NORMAL : m;
  endfunction

  // Avalon decode: one wait cycle, then the access completes
  assign hit               = (avs_address_i == OSC_MODE_ADDR);
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_take           = avs_write_i && ack_q && hit && avs_byteenable_i[0];

  // Access acknowledge flop
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read_i || avs_write_i) && !ack_q;
    end
  end

  // Read data, ready at the completing edge; unused bits and other addresses read zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      avs_readdata_o <= hit ? {27'h000_0000, operating_mode_q,
                               clock_source_select_q, high_osc_stop_q, 1'b0}
                            : 32'h0000_0000;
    end
  end

  // Hardware clears the mode field when a wake completes
  assign sleep_exit = (state_q == ST_WAKE) && fast_tick &&
                      (tick_cnt_q == WAKE_TICKS - 12'h001);
  assign wake_clear = sleep_exit || ((state_q == ST_GREEN) &&
                      (port_change || timer_ovf_i));

  // Operating mode field
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      operating_mode_q <= OSC_MODE_RESET[MODE_MSB:MODE_LSB];
    end else if (wake_clear) begin
      operating_mode_q <= MODE_NORMAL;
    end else if (wr_take) begin
      operating_mode_q <= mode_of(avs_writedata_i[7:0]);
    end
  end

  // Clock select and high oscillator stop; a sleep wake lands in normal mode
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      clock_source_select_q <= OSC_MODE_RESET[CLK_SEL_BIT];
      high_osc_stop_q       <= OSC_MODE_RESET[HIGH_STOP_BIT];
    end else if (sleep_exit) begin
      clock_source_select_q <= 1'b0;
      high_osc_stop_q       <= 1'b0;
    end else if (wr_take) begin
      clock_source_select_q <= avs_writedata_i[CLK_SEL_BIT];
      high_osc_stop_q       <= avs_writedata_i[HIGH_STOP_BIT];
    end
  end

  // Oscillator synchronisers; edges are taken from the second and third stages
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      fast_sy_q <= 3'h0;
      slow_sy_q <= 3'h0;
    end else begin
      fast_sy_q <= {fast_sy_q[1:0], fast_osc_i};
      slow_sy_q <= {slow_sy_q[1:0], slow_osc_i};
    end
  end

  // One tick per oscillator rising edge, only while that oscillator is enabled
  assign fast_tick = fast_sy_q[1] && !fast_sy_q[2] && high_osc_en_o;
  assign slow_tick = slow_sy_q[1] && !slow_sy_q[2] && slow_rc_en_o;

  // Wake port synchroniser and level change detector
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      port_sy1_q <= '0;
      port_sy2_q <= '0;
      port_old_q <= '0;
    end else begin
      port_sy1_q <= wake_port_i;
      port_sy2_q <= port_sy1_q;
      port_old_q <= port_sy2_q;
    end
  end

  assign port_change = (port_sy2_q != port_old_q);

  // Mode sequencer: start-up wait, run, green, sleep and sleep wake settling
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= ST_BOOT;
    end else begin
      case (state_q)
        ST_BOOT: begin
          if (fast_tick && tick_cnt_q == START_TICKS - 12'h001) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (operating_mode_q == MODE_SLEEP) begin
            state_q <= ST_SLEEP;
          end else if (operating_mode_q == MODE_GREEN) begin
            state_q <= ST_GREEN;
          end
        end
        ST_GREEN: begin
          if (port_change || timer_ovf_i) begin
            state_q <= ST_RUN;
          end
        end
        ST_SLEEP: begin
          if (port_change) begin
            state_q <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (sleep_exit) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_BOOT;
        end
      endcase
    end
  end

  // Settling counter in high oscillator ticks, for start-up and sleep wake
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tick_cnt_q <= 12'h000;
    end else if (state_q != ST_BOOT && state_q != ST_WAKE) begin
      tick_cnt_q <= 12'h000;
    end else if (fast_tick) begin
      tick_cnt_q <= tick_cnt_q + 12'h001;
    end
  end

  // Active source follows the select bit at a safe low phase point, or at once while the divider is not running
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sel_slow_q <= 1'b0;
    end else if (!run_div || boundary) begin
      sel_slow_q <= clock_source_select_q;
    end
  end

  // Oscillator enables; slow RC has no private stop bit
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      high_osc_en_o <= 1'b1;
      slow_rc_en_o  <= 1'b1;
    end else begin
      high_osc_en_o <= (state_q == ST_WAKE) || ((state_q != ST_SLEEP) &&
                       !(high_osc_stop_q && sel_slow_q));
      slow_rc_en_o  <= (state_q != ST_SLEEP) && (state_q != ST_WAKE) &&
                       !((state_q == ST_GREEN) && (HIGH_CLK_OPT == HIGH_CLOCK_CONFIG_XTAL_32K) &&
                         !WDT_EN);
    end
  end

  // Pin roles from the build option
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      osc_input_gpio_o  <= 1'b0;
      osc_output_gpio_o <= 1'b0;
    end else begin
      osc_input_gpio_o  <= (HIGH_CLK_OPT == HIGH_CLOCK_CONFIG_INT_FAST_RC);
      osc_output_gpio_o <= RC_TYPE;
    end
  end

  // Watchdog tick from the slow RC
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      wdt_tick_o <= 1'b0;
    end else begin
      wdt_tick_o <= slow_tick;
    end
  end

  // Source tick and divide factor feeding the instruction clock divider
  assign run_div    = (state_q == ST_RUN);
  assign src_tick   = sel_slow_q ? slow_tick : fast_tick;
  assign src_div    = sel_slow_q ? SLOW_DIV : FAST_DIV;
  assign cpu_run_o  = run_div;
  assign slow_sel_o = sel_slow_q;

  cmc_cpu_div u_div (
    .clk_i      (clk_i),
    .rst_b_i    (rst_b_i),
    .run_i      (run_div),
    .tick_i     (src_tick),
    .div_i      (src_div),
    .cpu_clk_o  (cpu_clk_o),
    .cpu_tick_o (cpu_tick_o),
    .boundary_o (boundary)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_in_sleep;
    state_q == ST_SLEEP ##1 state_q == ST_SLEEP;
  endsequence

  property p_sleep_stops;
    s_in_sleep |-> !high_osc_en_o && !slow_rc_en_o;
  endproperty
  a_sleep_stops: assert property (p_sleep_stops) else $error("oscillator runs in sleep");

  sequence s_wake_done;
    state_q == ST_WAKE ##1 state_q == ST_RUN;
  endsequence

  property p_wake_wait;
    s_wake_done |-> $past(tick_cnt_q) == WAKE_TICKS - 12'h001 && !clock_source_select_q;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("sleep wake settle count wrong");

  sequence s_green_exit;
    state_q == ST_GREEN ##1 state_q == ST_RUN;
  endsequence

  property p_green_return;
    s_green_exit |-> $stable(clock_source_select_q) && operating_mode_q == MODE_NORMAL;
  endproperty
  a_green_return: assert property (p_green_return) else $error("green wake lost mode");

  property p_sleep_timer_ignored;
    (state_q == ST_SLEEP && !port_change) |=> state_q == ST_SLEEP;
  endproperty
  a_sleep_timer_ignored: assert property (p_sleep_timer_ignored) else $error("bad sleep wake");

  property p_slow_rc_stop;
    !slow_rc_en_o |-> $past(state_q) == ST_SLEEP || $past(state_q) == ST_WAKE ||
                      ($past(state_q) == ST_GREEN && HIGH_CLK_OPT == HIGH_CLOCK_CONFIG_XTAL_32K && !WDT_EN);
  endproperty
  a_slow_rc_stop: assert property (p_slow_rc_stop) else $error("slow RC stopped wrongly");

  property p_switch_safe;
    (run_div && $past(run_div) && $changed(sel_slow_q)) |-> $past(boundary);
  endproperty
  a_switch_safe: assert property (p_switch_safe) else $error("source switched mid cycle");

  property p_reserved_mode;
    (wr_take && avs_writedata_i[MODE_MSB:MODE_LSB] == MODE_RSVD && !wake_clear)
      |=> operating_mode_q == MODE_NORMAL;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode) else $error("reserved mode stored");

  property p_bus_answer;
    (avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_high_stop;
    (high_osc_stop_q && sel_slow_q && state_q == ST_RUN) |=> !high_osc_en_o;
  endproperty
  a_high_stop: assert property (p_high_stop) else $error("high oscillator not stopped");

  property p_pins;
    $past(rst_b_i) |-> osc_input_gpio_o == (HIGH_CLK_OPT == HIGH_CLOCK_CONFIG_INT_FAST_RC) &&
                       osc_output_gpio_o == RC_TYPE;
  endproperty
  a_pins: assert property (p_pins) else $error("oscillator pin role wrong");

endmodule
`default_nettype wire

// File: src/cmc_pkg.sv
`default_nettype none
package cmc_pkg;

  // Register placement: printed offset is a register index, byte address is four times it
  localparam logic [7:0]  OSC_MODE_IDX      = 8'hCA;
  localparam logic [11:0] OSC_MODE_ADDR     = {2'h0, OSC_MODE_IDX, 2'h0};
  localparam logic [7:0]  OSC_MODE_RESET    = 8'h00;

  // Field positions inside the oscillator mode control register
  localparam int          HIGH_STOP_BIT     = 1;
  localparam int          CLK_SEL_BIT       = 2;
  localparam int          MODE_LSB          = 3;
  localparam int          MODE_MSB          = 4;

  // Operating mode field codes
  localparam logic [1:0]  MODE_NORMAL       = 2'h0;
  localparam logic [1:0]  MODE_SLEEP        = 2'h1;
  localparam logic [1:0]  MODE_GREEN        = 2'h2;
  localparam logic [1:0]  MODE_RSVD         = 2'h3;

  // Divider and timing counts, in oscillator ticks
  localparam logic [4:0]  SLOW_DIV          = 5'h04;
  localparam int          CPU_DIV_MIN       = 4;
  localparam int          CPU_DIV_MAX       = 16;
  localparam logic [11:0] WAKE_TICKS        = 12'h800;
  localparam logic [11:0] STARTUP_RC_TICKS  = 12'h040;
  localparam logic [11:0] STARTUP_XTAL_TICKS = 12'h800;

  // Build-time high clock source
  typedef enum logic [2:0] {
    HIGH_CLOCK_CONFIG_INT_FAST_RC,
    HIGH_CLOCK_CONFIG_EXT_RC,
    HIGH_CLOCK_CONFIG_XTAL_32K,
    HIGH_CLOCK_CONFIG_XTAL_12M,
    HIGH_CLOCK_CONFIG_XTAL_4M
  } cmc_high_clock_config_t;

  // Clock controller sequencing states
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_RUN,
    ST_GREEN,
    ST_SLEEP,
    ST_WAKE
  } cmc_state_t;

endpackage
`default_nettype wire

// File: src/cmc_cpu_div.sv
`timescale 1ns/1ns
`default_nettype none
module cmc_cpu_div
  import cmc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic       tick_i,
  input  wire logic [4:0] div_i,
  output logic            cpu_clk_o,
  output logic            cpu_tick_o,
  output logic            boundary_o
);

  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic       wrap;

  // Half period of the instruction clock for a given divide factor
  function automatic logic [4:0] half_of(input logic [4:0] div);
    half_of = {1'b0, div[4:1]};
  endfunction

  // Next count, wrapping at the divide factor
  assign wrap  = (cnt_q == div_i - 5'h01);
  assign cnt_d = wrap ? 5'h00 : cnt_q + 5'h01;

  // Phase counter; low phase starts at zero so a switch never cuts a high pulse
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !run_i) begin
      cnt_q <= 5'h00;
    end else if (tick_i) begin
      cnt_q <= cnt_d;
    end
  end

  // Instruction clock level and end-of-cycle pulse
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !run_i) begin
      cpu_clk_o  <= 1'b0;
      cpu_tick_o <= 1'b0;
    end else begin
      cpu_clk_o  <= tick_i ? (cnt_d >= half_of(div_i)) : cpu_clk_o;
      cpu_tick_o <= tick_i && wrap;
    end
  end

  // Safe point for changing source or factor
  assign boundary_o = (cnt_q == 5'h00);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_period_end;
    cpu_tick_o |-> $past(tick_i) && ($past(cnt_q) == $past(div_i) - 5'h01);
  endproperty
  a_period_end: assert property (p_period_end) else $error("instruction tick off period");

  property p_low_at_boundary;
    (run_i && boundary_o && $past(run_i)) |-> !cpu_clk_o;
  endproperty
  a_low_at_boundary: assert property (p_low_at_boundary) else $error("clock high at switch point");

endmodule
`default_nettype wire

// File: sim/dual_clock_mode_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_clock_mode_control_tb
  import cmc_pkg::*;
;
  localparam int DIV = 5;

  logic        clk_i;
  logic        rst_b_i;
  logic [11:0] avs_address_i;
  logic        avs_read_i, avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        fast_osc_i = 1'b0;
  logic        slow_osc_i = 1'b0;
  logic        timer_ovf_i;
  logic [7:0]  wake_port_i;
  logic        high_osc_en_o, slow_rc_en_o, osc_input_gpio_o, osc_output_gpio_o;
  logic        cpu_clk_o, cpu_tick_o, cpu_run_o, wdt_tick_o, slow_sel_o;
  logic [7:0]  osc_cnt = 8'h00;
  logic [31:0] rdat;
  int          fails, n_compared, cyc, min_hi, hi_len, n;

  cmc_clock_ctrl #(
    .HIGH_CLK_OPT   (HIGH_CLOCK_CONFIG_XTAL_32K),
    .CPU_DIV        (DIV),
    .WDT_EN         (1'b0),
    .WAKE_W         (8),
    .RC_START_TICKS (12'h008),
    .XT_START_TICKS (12'h008)
  ) cmc_clock_ctrl_inst (
    .clk_i (clk_i), .rst_b_i (rst_b_i),
    .avs_address_i (avs_address_i), .avs_read_i (avs_read_i), .avs_write_i (avs_write_i),
    .avs_writedata_i (avs_writedata_i), .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o (avs_readdata_o), .avs_waitrequest_o (avs_waitrequest_o),
    .fast_osc_i (fast_osc_i), .slow_osc_i (slow_osc_i),
    .wake_port_i (wake_port_i), .timer_ovf_i (timer_ovf_i),
    .high_osc_en_o (high_osc_en_o), .slow_rc_en_o (slow_rc_en_o),
    .osc_input_gpio_o (osc_input_gpio_o), .osc_output_gpio_o (osc_output_gpio_o),
    .cpu_clk_o (cpu_clk_o), .cpu_tick_o (cpu_tick_o), .cpu_run_o (cpu_run_o),
    .wdt_tick_o (wdt_tick_o), .slow_sel_o (slow_sel_o)
  );

  // System clock, 4 ns period
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Oscillator models: fast period 4 cycles, slow 16 cycles, frozen while disabled
  always @(posedge clk_i) begin
    osc_cnt <= osc_cnt + 8'h01;
    if (high_osc_en_o === 1'b1) fast_osc_i <= osc_cnt[1];
    if (slow_rc_en_o === 1'b1) slow_osc_i <= osc_cnt[3];
  end

  // Hang guard
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      fails++;
      report_and_stop();
    end
  end

  // Shortest high phase of the running instruction clock
  always @(negedge clk_i) begin
    if (cpu_run_o !== 1'b1) hi_len = 0;
    else if (cpu_clk_o === 1'b1) hi_len = hi_len + 1;
    else begin
      if (hi_len > 0 && hi_len < min_hi) min_hi = hi_len;
      hi_len = 0;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input bit is_wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int w;
    w = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= b;
    avs_write_i <= is_wr;
    avs_read_i <= !is_wr;
    // Waitrequest and read data are taken as they stand at the completing edge
    do begin
      @(posedge clk_i);
      w++;
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    check("bus answer", 32'(w), 32'h0000_0002);
  endtask

  task automatic wr(input logic [31:0] d);
    bus(1'b1, OSC_MODE_ADDR, d, 4'hf, rdat);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] exp);
    bus(1'b0, OSC_MODE_ADDR, 32'h0000_0000, 4'hf, rdat);
    check(what, rdat, exp);
  endtask

  task automatic wait_run(input logic v, input int lim, output int c);
    c = 0;
    while (cpu_run_o !== v && c < lim) begin
      @(negedge clk_i);
      c++;
    end
  endtask

  // Cycles between two instruction ticks, second interval of a pair
  task automatic tick_gap(output int g);
    repeat (2) begin
      g = 0;
      do begin
        @(negedge clk_i);
        g++;
      end while (cpu_tick_o !== 1'b1 && g < 500);
    end
  endtask

  task automatic pulse_timer();
    @(posedge clk_i);
    timer_ovf_i <= 1'b1;
    @(posedge clk_i);
    timer_ovf_i <= 1'b0;
  endtask

  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b_i = 1'b0;
    avs_address_i = 12'h000;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'h0;
    timer_ovf_i = 1'b0;
    wake_port_i = 8'h00;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    min_hi = 1000;
    hi_len = 0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    wait_run(1'b1, 200, n);
    check("startup wait", 32'(n >= 28 && n <= 60), 32'h0000_0001);
    check("pin roles", 32'({osc_input_gpio_o, osc_output_gpio_o}), 32'h0000_0000);
    rd_chk("reset value", 32'h0000_0000);
    tick_gap(n);
    check("normal period", 32'(n), 32'(4 * DIV));
    n = 0;
    repeat (64) begin
      @(negedge clk_i);
      if (wdt_tick_o === 1'b1) n++;
    end
    check("watchdog ticks", 32'(n >= 4 && n <= 8), 32'h0000_0001);
    // Unmapped place and a write without its byte lane
    bus(1'b1, OSC_MODE_ADDR + 12'h004, 32'h0000_001e, 4'hf, rdat);
    bus(1'b0, OSC_MODE_ADDR + 12'h004, 32'h0000_0000, 4'hf, rdat);
    check("unmapped read", rdat, 32'h0000_0000);
    bus(1'b1, OSC_MODE_ADDR, 32'h0000_0006, 4'h0, rdat);
    rd_chk("masked write", 32'h0000_0000);
    wr(32'h0000_00ff);
    rd_chk("loose bits", 32'h0000_0006);
    repeat (200) @(negedge clk_i);
    check("slow state", 32'({slow_sel_o, high_osc_en_o, slow_rc_en_o}), 32'h0000_0005);
    tick_gap(n);
    check("slow period", 32'(n), 32'h0000_0040);
    // Green from slow mode, woken by the port
    wr(32'h0000_0016);
    repeat (4) @(negedge clk_i);
    check("green entry", 32'({cpu_run_o, slow_rc_en_o}), 32'h0000_0000);
    @(posedge clk_i);
    wake_port_i <= 8'h08;
    wait_run(1'b1, 30, n);
    check("green port wake", 32'(n < 30), 32'h0000_0001);
    rd_chk("green return", 32'h0000_0006);
    check("slow kept", 32'(slow_sel_o), 32'h0000_0001);
    wr(32'h0000_0000);
    repeat (100) @(negedge clk_i);
    check("high restart", 32'({high_osc_en_o, slow_sel_o}), 32'h0000_0002);
    tick_gap(n);
    check("normal again", 32'(n), 32'(4 * DIV));
    // Green from normal mode, woken by the timer
    wr(32'h0000_0010);
    repeat (4) @(negedge clk_i);
    check("green halt", 32'(cpu_run_o), 32'h0000_0000);
    pulse_timer();
    wait_run(1'b1, 20, n);
    check("timer wake", 32'(n < 20), 32'h0000_0001);
    rd_chk("timer return", 32'h0000_0000);
    // Sleep: timer ignored, port wake waits for the oscillator
    wr(32'h0000_0008);
    repeat (4) @(negedge clk_i);
    check("sleep stops", 32'({high_osc_en_o, slow_rc_en_o, cpu_run_o}), 32'h0000_0000);
    pulse_timer();
    repeat (20) @(negedge clk_i);
    check("sleep timer", 32'(cpu_run_o), 32'h0000_0000);
    @(posedge clk_i);
    wake_port_i <= 8'h00;
    wait_run(1'b1, 12000, n);
    check("sleep wake time", 32'(n >= 8180 && n <= 8260), 32'h0000_0001);
    rd_chk("sleep wake mode", 32'h0000_0000);
    check("clock pulse width", 32'(min_hi >= 8), 32'h0000_0001);
    report_and_stop();
  end
endmodule
`default_nettype wire
